// [shared/pmd_pkg.sv]
// Purpose : Shared constants for the PMU mode, sense and clamp decode block
// Assumes : APB slave with 32-bit data, one aligned word per register
// Notes   : Offsets are byte addresses
package pmd_pkg;

	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [7:0] PMD_OFS_CTRL0   = 8'h00;
	localparam logic [7:0] PMD_OFS_CTRL1   = 8'h04;
	localparam logic [7:0] PMD_OFS_SHARED  = 8'h08;
	localparam logic [7:0] PMD_OFS_STATUS  = 8'h0C;
	localparam logic [7:0] PMD_OFS_IRQ_ST  = 8'h10;
	localparam logic [7:0] PMD_OFS_IRQ_EN  = 8'h14;
	localparam logic [7:0] PMD_OFS_IRQ_CLR = 8'h18;

	// ********************************************************************
	// Per-channel control field layout
	// ********************************************************************
	localparam int PMD_B_FORCE_EN   = 0;
	localparam int PMD_B_FORCE_MODE_SEL      = 1;
	localparam int PMD_B_MEASURE_MODE_SEL      = 2;
	localparam int PMD_B_SENSE      = 3;
	localparam int PMD_B_CLAMP      = 4;
	localparam int PMD_B_MEASURE_OUTPUT_EN    = 5;
	localparam int PMD_B_CMP_EN     = 6;
	localparam int PMD_B_RANGE_LO   = 7;
	localparam int PMD_CTRL_W       = 10;
	localparam logic [9:0] PMD_CTRL_RST = 10'h000;

	// Shared switch bits
	localparam int PMD_B_EXT_FORCE  = 0;
	localparam int PMD_B_EXT_SENSE  = 1;
	localparam logic [1:0] PMD_SHARED_RST = 2'h0;

	// Status word per channel (8 bits each)
	localparam int PMD_STAT_W       = 8;
	localparam int PMD_NCH          = 2;

	// ********************************************************************
	// Current ranges, one-hot, and sense path codes
	// ********************************************************************
	typedef enum logic [4:0] {
		PMD_RANGE_A = 5'h01,
		PMD_RANGE_B = 5'h02,
		PMD_RANGE_C = 5'h04,
		PMD_RANGE_D = 5'h08,
		PMD_RANGE_E = 5'h10
	} pmd_range_e;

	typedef enum logic [2:0] {
		PMD_SENSE_INT = 3'h1,
		PMD_SENSE_EXT = 3'h2,
		PMD_SENSE_GND = 3'h4
	} pmd_sense_e;

	localparam logic [2:0] PMD_RS_E = 3'h0;
	localparam logic [2:0] PMD_RS_D = 3'h1;
	localparam logic [2:0] PMD_RS_C = 3'h2;
	localparam logic [2:0] PMD_RS_B = 3'h3;

endpackage

// [hw/pmd_chan_decode.sv]
// Purpose : Combinational mode, sense, clamp and range decode, one channel
// Assumes : Control bits come from registers, pins synchronous to the clock
// Notes   : No state; the parent registers the outputs
`timescale 1ns/1ps
module pmd_chan_decode
	import pmd_pkg::*;
(
	// Control word and logic inputs
	input  wire logic [9:0] ctrl_i,
	input  wire logic       low_leak_pin_n_i,
	input  wire logic       measure_output_out_enable_pin_i,
	// Decoded controls
	output logic            force_active_o,
	output logic            force_current_o,
	output logic            measure_output_current_o,
	output logic [2:0]      sense_o,
	output logic            measure_output_drive_o,
	output logic            vclamp_on_o,
	output logic            iclamp_on_o,
	output logic            win_on_current_o,
	output logic            win_on_ext_o,
	output logic            flags_drive_o,
	output logic [4:0]      range_o
);
	import pmd_pkg::*;

	// ********************************************************************
	// Named control bits
	// ********************************************************************
	wire       force_out_enable_bit = ctrl_i[PMD_B_FORCE_EN];
	wire       force_mode_sel       = ctrl_i[PMD_B_FORCE_MODE_SEL];
	wire       measure_mode_sel     = ctrl_i[PMD_B_MEASURE_MODE_SEL];
	wire       sense_path_sel       = ctrl_i[PMD_B_SENSE];
	wire       clamp_enable_bit     = ctrl_i[PMD_B_CLAMP];
	wire       measure_output_out_enable_bit  = ctrl_i[PMD_B_MEASURE_OUTPUT_EN];
	wire [2:0] current_range_sel    = ctrl_i[PMD_B_RANGE_LO +: 3];

	// ********************************************************************
	// Force and measure selection
	// ********************************************************************
	// Both controls are ANDed: pin low, or force bit low with mode 1, parks the output in low leakage
	assign force_active_o = force_out_enable_bit & low_leak_pin_n_i;
	// Force bit low with mode 0 is the FV calibration mode: still driving
	wire   fv_cal         = low_leak_pin_n_i & ~force_out_enable_bit
	                        & ~force_mode_sel;
	wire   forcing        = force_active_o | fv_cal;
	assign force_current_o = force_active_o & force_mode_sel;
	assign measure_output_current_o  = forcing & measure_mode_sel;
	// Force-nothing with measure bit 0 grounds the sense amp
	wire   sense_gnd      = ~forcing & ~measure_mode_sel;
	assign sense_o = sense_gnd      ? PMD_SENSE_GND :
	                 sense_path_sel ? PMD_SENSE_EXT : PMD_SENSE_INT;

	// Measure output drives only with bit and pin both high
	assign measure_output_drive_o = measure_output_out_enable_bit & measure_output_out_enable_pin_i;

	// ********************************************************************
	// Clamps and window comparator
	// ********************************************************************
	// Voltage clamps sense the pin itself, so no sense path term here
	assign vclamp_on_o = clamp_enable_bit & force_current_o;
	assign iclamp_on_o = clamp_enable_bit & forcing
	                     & ~force_current_o;
	assign win_on_current_o = measure_output_current_o;
	assign win_on_ext_o     = ~measure_output_current_o & ~sense_gnd
	                          & sense_path_sel;
	assign flags_drive_o    = ctrl_i[PMD_B_CMP_EN];

	// ********************************************************************
	// Current range; range A is refused while the output is high-Z
	// ********************************************************************
	assign range_o =
		(current_range_sel == PMD_RS_E) ? PMD_RANGE_E :
		(current_range_sel == PMD_RS_D) ? PMD_RANGE_D :
		(current_range_sel == PMD_RS_C) ? PMD_RANGE_C :
		(current_range_sel == PMD_RS_B) ? PMD_RANGE_B :
		force_active_o ? PMD_RANGE_A : PMD_RANGE_B;

endmodule

// [hw/pmd_apb_slave.sv]
// Purpose : APB register file for the PMU decode block
// Assumes : Zero-wait APB, pready always high during access
// Notes   : Unmapped reads return zero with pslverr high
`timescale 1ns/1ps
module pmd_apb_slave
	import pmd_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	// APB
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Register contents and status
	input  wire logic [15:0] status_i,
	input  wire logic [1:0]  irq_event_i,
	output logic      [9:0]  ctrl0_o,
	output logic      [9:0]  ctrl1_o,
	output logic      [1:0]  shared_o,
	output logic             irq_o
);
	import pmd_pkg::*;

	logic [1:0]  irq_st;
	logic [1:0]  irq_en;

	// ********************************************************************
	// Decode
	// ********************************************************************
	wire access  = psel_i & penable_i;
	wire wr      = access & pwrite_i;
	wire hit_c0  = paddr_i == PMD_OFS_CTRL0;
	wire hit_c1  = paddr_i == PMD_OFS_CTRL1;
	wire hit_sh  = paddr_i == PMD_OFS_SHARED;
	wire hit_st  = paddr_i == PMD_OFS_STATUS;
	wire hit_is  = paddr_i == PMD_OFS_IRQ_ST;
	wire hit_ie  = paddr_i == PMD_OFS_IRQ_EN;
	wire hit_ic  = paddr_i == PMD_OFS_IRQ_CLR;
	wire mapped  = hit_c0 | hit_c1 | hit_sh | hit_st | hit_is | hit_ie
	               | hit_ic;
	wire [1:0] clr = (wr & hit_ic) ? pwdata_i[1:0] : 2'h0;
	wire [31:0] rdata =
		hit_c0 ? {22'h0, ctrl0_o} :
		hit_c1 ? {22'h0, ctrl1_o} :
		hit_sh ? {30'h0, shared_o} :
		hit_st ? {16'h0, status_i} :
		hit_is ? {30'h0, irq_st} :
		hit_ie ? {30'h0, irq_en} : 32'h0;

	// Control words commit only on a completed write; power-up disables
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctrl0_o  <= PMD_CTRL_RST;
			ctrl1_o  <= PMD_CTRL_RST;
			shared_o <= PMD_SHARED_RST;
			irq_en   <= 2'h0;
		end else if (wr) begin
			if (hit_c0) ctrl0_o <= pwdata_i[9:0];
			if (hit_c1) ctrl1_o <= pwdata_i[9:0];
			if (hit_sh) shared_o <= pwdata_i[1:0];
			if (hit_ie) irq_en <= pwdata_i[1:0];
		end
	end

	// Sticky events; a set in the clear cycle wins
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			irq_st <= 2'h0;
			irq_o  <= 1'b0;
		end else begin
			irq_st <= (irq_st & ~clr) | irq_event_i;
			irq_o  <= |(((irq_st & ~clr) | irq_event_i) & irq_en);
		end
	end

	// Read data and answer
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			prdata_o  <= 32'h0;
			pslverr_o <= 1'b0;
		end else if (psel_i & ~penable_i) begin
			prdata_o  <= rdata;
			pslverr_o <= ~mapped;
		end
	end

	assign pready_o = 1'b1;

endmodule

// [hw/pmd_top.sv]
// Purpose : Two-channel PMU mode, sense, clamp and range decode with APB
// Assumes : 20 MHz mclk_i, all pins synchronous to it
// Notes   : Every output but pready_o is registered, one cycle behind its cause
//
// Functional notes
// - Both force enables high forces per the mode bits, sense bit 0 internal, 1 external.
// - Force disabled by the force bit with mode 1 or by the pin is high-Z; measure bit picks none with ground or voltage.
// - The force output is low leakage whenever the leakage pin is low, or the force bit is low with mode 1.
// - Force enable and measure output enable bits reset to 0.
// - The measure output drives only when its bit and its pin are both 1.
// - The clamp bit enables voltage and current clamps together.
// - Voltage clamps act only in force-current mode with clamps enabled, from the pin voltage.
// - Current clamps act only in force-voltage mode with clamps enabled.
// - The measure bit picks voltage or current for the window comparator.
// - When voltage is monitored, the sense bit picks external input or pin.
// - Force and measure selections are independent and give six modes.
// - Shared external force and sense switches follow their own bits.
// - Range codes map to E, D, C, B, and a leading 1 to A while force is active, else B.
// - One enable bit floats both window flags when 0, else they report.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module pmd_top
	import pmd_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	// APB
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             irq_o,
	// Per-channel logic inputs
	input  wire logic [1:0]  low_leak_pin_n_i,
	input  wire logic [1:0]  measure_output_out_enable_pin_i,
	input  wire logic [1:0]  win_above_i,
	input  wire logic [1:0]  win_below_i,
	// Per-channel decoded controls
	output logic      [1:0]  force_active_o,
	output logic      [1:0]  force_current_o,
	output logic      [1:0]  measure_output_current_o,
	output logic      [5:0]  sense_o,
	output logic      [1:0]  measure_output_drive_o,
	output logic      [1:0]  vclamp_on_o,
	output logic      [1:0]  iclamp_on_o,
	output logic      [1:0]  win_on_current_o,
	output logic      [1:0]  win_on_ext_o,
	output logic      [9:0]  range_o,
	// Window flags, open drain
	output logic      [1:0]  flag_hi_o,
	output logic      [1:0]  flag_hi_oe_o,
	output logic      [1:0]  flag_lo_o,
	output logic      [1:0]  flag_lo_oe_o,
	// Shared switches
	output logic             ext_force_switch_o,
	output logic             ext_sense_switch_o
);
	import pmd_pkg::*;

	logic [9:0]  ctrl   [PMD_NCH];
	logic [1:0]  shared;
	logic [15:0] status;
	logic [1:0]  ev_out;
	logic [1:0]  fa_c, fc_c, mc_c, md_c, vc_c, ic_c, wc_c, we_c, fd_c;
	logic [5:0]  se_c;
	logic [9:0]  rg_c;
	logic [1:0]  fa_q;

	// ********************************************************************
	// Register file
	// ********************************************************************
	pmd_apb_slave u_regs (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.psel_i      (psel_i),
		.penable_i   (penable_i),
		.pwrite_i    (pwrite_i),
		.paddr_i     (paddr_i),
		.pwdata_i    (pwdata_i),
		.prdata_o    (prdata_o),
		.pready_o    (pready_o),
		.pslverr_o   (pslverr_o),
		.status_i    (status),
		.irq_event_i (ev_out),
		.ctrl0_o     (ctrl[0]),
		.ctrl1_o     (ctrl[1]),
		.shared_o    (shared),
		.irq_o       (irq_o)
	);

	// ********************************************************************
	// Per-channel decode
	// ********************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < PMD_NCH; ch++) begin : g_ch
			pmd_chan_decode u_dec (
				.ctrl_i                (ctrl[ch]),
				.low_leak_pin_n_i      (low_leak_pin_n_i[ch]),
				.measure_output_out_enable_pin_i (measure_output_out_enable_pin_i[ch]),
				.force_active_o        (fa_c[ch]),
				.force_current_o       (fc_c[ch]),
				.measure_output_current_o        (mc_c[ch]),
				.sense_o               (se_c[3*ch +: 3]),
				.measure_output_drive_o          (md_c[ch]),
				.vclamp_on_o           (vc_c[ch]),
				.iclamp_on_o           (ic_c[ch]),
				.win_on_current_o      (wc_c[ch]),
				.win_on_ext_o          (we_c[ch]),
				.flags_drive_o         (fd_c[ch]),
				.range_o               (rg_c[5*ch +: 5])
			);
			// Status: low 8 bits channel 0, next 8 channel 1
			assign status[PMD_STAT_W*ch +: PMD_STAT_W] =
				{win_below_i[ch], win_above_i[ch], fd_c[ch], md_c[ch],
				 mc_c[ch], fc_c[ch], 1'b0, fa_c[ch]};
		end
	endgenerate

	// Event: force output dropped out of its active state
	assign ev_out = fa_q & ~fa_c;

	// ********************************************************************
	// Output registers; one cycle of latency from any cause
	// ********************************************************************
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			fa_q               <= 2'h0;
			force_active_o     <= 2'h0;
			force_current_o    <= 2'h0;
			measure_output_current_o     <= 2'h0;
			sense_o            <= 6'h0;
			measure_output_drive_o       <= 2'h0;
			vclamp_on_o        <= 2'h0;
			iclamp_on_o        <= 2'h0;
			win_on_current_o   <= 2'h0;
			win_on_ext_o       <= 2'h0;
			range_o            <= 10'h0;
			ext_force_switch_o <= 1'b0;
			ext_sense_switch_o <= 1'b0;
		end else begin
			fa_q               <= fa_c;
			force_active_o     <= fa_c;
			force_current_o    <= fc_c;
			measure_output_current_o     <= mc_c;
			sense_o            <= se_c;
			measure_output_drive_o       <= md_c;
			vclamp_on_o        <= vc_c;
			iclamp_on_o        <= ic_c;
			win_on_current_o   <= wc_c;
			win_on_ext_o       <= we_c;
			range_o            <= rg_c;
			ext_force_switch_o <= shared[PMD_B_EXT_FORCE];
			ext_sense_switch_o <= shared[PMD_B_EXT_SENSE];
		end
	end

	// Flags are open drain: pulled low only, released when disabled
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			flag_hi_o    <= 2'h0;
			flag_lo_o    <= 2'h0;
			flag_hi_oe_o <= 2'h0;
			flag_lo_oe_o <= 2'h0;
		end else begin
			flag_hi_o    <= 2'h0;
			flag_lo_o    <= 2'h0;
			flag_hi_oe_o <= fd_c & win_above_i;
			flag_lo_oe_o <= fd_c & win_below_i;
		end
	end

endmodule

// [sim/pmd_top_assertions.sv]
// Purpose : Port-level checks of the PMU decode block
// Assumes : Outputs registered one edge behind their cause
// Notes   : Vector forms check both channels at once
`timescale 1ns/1ps
module pmd_chk
	import pmd_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	// Logic inputs
	input  wire logic [1:0] low_leak_pin_n_i,
	input  wire logic [1:0] measure_output_out_enable_pin_i,
	input  wire logic [1:0] win_above_i,
	input  wire logic [1:0] win_below_i,
	// Decoded controls
	input  wire logic [1:0] force_active_o,
	input  wire logic [1:0] force_current_o,
	input  wire logic [1:0] measure_output_current_o,
	input  wire logic [5:0] sense_o,
	input  wire logic [1:0] measure_output_drive_o,
	input  wire logic [1:0] vclamp_on_o,
	input  wire logic [1:0] iclamp_on_o,
	input  wire logic [1:0] win_on_current_o,
	input  wire logic [1:0] win_on_ext_o,
	input  wire logic [9:0] range_o,
	input  wire logic [1:0] flag_hi_o,
	input  wire logic [1:0] flag_hi_oe_o,
	input  wire logic [1:0] flag_lo_o,
	input  wire logic [1:0] flag_lo_oe_o,
	input  wire logic       irq_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	force_off_a: assert property ((force_active_o & ~$past(low_leak_pin_n_i)) == 2'h0)
		else $error("force active with leak pin low");
	measure_output_hiz_a: assert property ((measure_output_drive_o & ~$past(measure_output_out_enable_pin_i)) == 2'h0)
		else $error("measure driven with enable pin low");
	vclamp_mode_a: assert property ((vclamp_on_o & ~force_current_o) == 2'h0)
		else $error("voltage clamp outside force current");
	iclamp_mode_a: assert property ((iclamp_on_o & force_current_o) == 2'h0)
		else $error("current clamp in force current");
	range_hiz_a: assert property ({range_o[5], range_o[0]} != 2'h0 |-> {range_o[5], range_o[0]} == ({range_o[5], range_o[0]} & force_active_o))
		else $error("range A while force output off");
	gnd_sense_a: assert property (({sense_o[5], sense_o[2]} & (force_active_o | measure_output_current_o)) == 2'h0)
		else $error("ground sense while forcing or measuring current");
	win_src_a: assert property ((win_on_ext_o & win_on_current_o) == 2'h0)
		else $error("window watches current and external at once");
	flag_pull_a: assert property ((flag_hi_oe_o & ~$past(win_above_i)) == 2'h0 && (flag_lo_oe_o & ~$past(win_below_i)) == 2'h0 && (flag_hi_o | flag_lo_o) == 2'h0)
		else $error("window flag pulled without cause");
	cur_force_a: assert property ((force_current_o & ~force_active_o) == 2'h0)
		else $error("force current without active force");

	// Main scenarios reached
	cover property (vclamp_on_o[0]);
	cover property (iclamp_on_o[1]);
	cover property (range_o[0]);
	cover property (irq_o);
endmodule

bind pmd_top pmd_chk chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.low_leak_pin_n_i(low_leak_pin_n_i), .measure_output_out_enable_pin_i(measure_output_out_enable_pin_i),
	.win_above_i(win_above_i), .win_below_i(win_below_i),
	.force_active_o(force_active_o), .force_current_o(force_current_o),
	.measure_output_current_o(measure_output_current_o), .sense_o(sense_o), .measure_output_drive_o(measure_output_drive_o),
	.vclamp_on_o(vclamp_on_o), .iclamp_on_o(iclamp_on_o), .range_o(range_o),
	.win_on_current_o(win_on_current_o), .win_on_ext_o(win_on_ext_o),
	.flag_hi_o(flag_hi_o), .flag_hi_oe_o(flag_hi_oe_o), .flag_lo_o(flag_lo_o),
	.flag_lo_oe_o(flag_lo_oe_o), .irq_o(irq_o));

// [sim/pmd_far_model.sv]
// Purpose : Window comparators and flag wires beside the decode block
// Assumes : One measured level per channel, eight bits each
// Notes   : Thresholds are plain defaults
`timescale 1ns/1ps
module pmd_far_model
(
	// Clock and measured levels
	input  wire logic        mclk_i,
	input  wire logic [15:0] level_i,
	// Open-drain enables from the block
	input  wire logic [1:0]  flag_hi_oe_i,
	input  wire logic [1:0]  flag_lo_oe_i,
	// Comparator results and resolved wires
	output logic      [1:0]  win_above_o,
	output logic      [1:0]  win_below_o,
	output logic      [1:0]  flag_hi_wire_o,
	output logic      [1:0]  flag_lo_wire_o
);
	localparam logic [7:0] WIN_UPPER = 8'hA0;
	localparam logic [7:0] WIN_LOWER = 8'h60;

	// Comparators settle once a cycle, like a sampled analog front end
	always_ff @(posedge mclk_i) begin
		win_above_o <= {level_i[15:8] > WIN_UPPER, level_i[7:0] > WIN_UPPER};
		win_below_o <= {level_i[15:8] < WIN_LOWER, level_i[7:0] < WIN_LOWER};
	end

	// Pull-up wins unless the block pulls low; floating reads high
	assign flag_hi_wire_o = ~flag_hi_oe_i;
	assign flag_lo_wire_o = ~flag_lo_oe_i;
endmodule

// [sim/tb_top.sv]
// Purpose : Self-checking bench for the PMU decode block
// Assumes : APB slave answers with pready, decode one edge late
// Notes   : Random control words from a fixed seed, corner words first
`timescale 1ns/1ps
module tb_top;
	import pmd_pkg::*;
	logic        mclk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0;
	logic        pwrite_i = 0, pready_o, pslverr_o, irq_o, er, efs, ess;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [1:0]  lp = 2'h0, mp = 2'h0, wa, wb, fa, fc, mc, md, vc, ic, wc, we;
	logic [1:0]  fh, fho, fl, flo, hw, lw;
	logic [5:0]  sn;
	logic [9:0]  rg, c0, c1;
	logic [15:0] lvl = 16'h0;
	int          seed = 68, bad_count = 0, num_checks = 0, i, ch;
	logic [9:0]  corner [8] = '{10'h381, 10'h380, 10'h01B, 10'h013,
		10'h00C, 10'h07D, 10'h016, 10'h11F};

	pmd_top dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .irq_o(irq_o), .low_leak_pin_n_i(lp),
		.measure_output_out_enable_pin_i(mp), .win_above_i(wa), .win_below_i(wb),
		.force_active_o(fa), .force_current_o(fc), .measure_output_current_o(mc),
		.sense_o(sn), .measure_output_drive_o(md), .vclamp_on_o(vc), .iclamp_on_o(ic),
		.win_on_current_o(wc), .win_on_ext_o(we), .range_o(rg),
		.flag_hi_o(fh), .flag_hi_oe_o(fho), .flag_lo_o(fl), .flag_lo_oe_o(flo),
		.ext_force_switch_o(efs), .ext_sense_switch_o(ess));
	pmd_far_model far_u (.mclk_i(mclk_i), .level_i(lvl), .flag_hi_oe_i(fho),
		.flag_lo_oe_i(flo), .win_above_o(wa), .win_below_o(wb),
		.flag_hi_wire_o(hw), .flag_lo_wire_o(lw));

	// ****************************************************************
	// Tasks and expectations
	// ****************************************************************
	task automatic check(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Called just after a rising edge; holds all until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	// Calibration FV still forces; range A only with force active
	function automatic logic [17:0] exp_ch(input logic [9:0] c, input logic l,
		m, a, b);
		logic f, g, fi, mi;
		logic [2:0] s;
		logic [4:0] r;
		f = c[0] & l;
		g = l & (c[0] | ~c[1]);
		fi = f & c[1];
		mi = g & c[2];
		s = (~g & ~c[2]) ? PMD_SENSE_GND : (c[3] ? PMD_SENSE_EXT : PMD_SENSE_INT);
		case (c[9:7])
			3'h0: r = PMD_RANGE_E;
			3'h1: r = PMD_RANGE_D;
			3'h2: r = PMD_RANGE_C;
			3'h3: r = PMD_RANGE_B;
			default: r = f ? PMD_RANGE_A : PMD_RANGE_B;
		endcase
		return {f, fi, mi, s, c[5] & m, c[4] & fi, c[4] & g & ~c[1], mi,
			~mi & s[1], r, ~(c[6] & a), ~(c[6] & b)};
	endfunction

	task automatic end_of_test;
		if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial forever #25 mclk_i = ~mclk_i;
	initial begin
		repeat (20000) @(posedge mclk_i);
		bad_count++;
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		// Pins high, so only the reset value of each enable bit decides
		lp        <= 2'b11;
		mp        <= 2'b11;
		@(posedge mclk_i);
		apb(1'b0, PMD_OFS_CTRL0, 32'h0);
		check("ctrl0 reset", rd, 32'h0);
		check("enables reset", {fa, md}, 4'h0);
		for (i = 0; i < 48; i++) begin
			c0 = (i < 8) ? corner[i] : 10'($random(seed));
			c1 = 10'($random(seed));
			lp <= (i < 8) ? 2'b11 : 2'($random(seed));
			mp <= (i < 8) ? 2'b11 : 2'($random(seed));
			lvl <= 16'($random(seed));
			apb(1'b1, PMD_OFS_CTRL0, {22'h0, c0});
			apb(1'b1, PMD_OFS_CTRL1, {22'h0, c1});
			repeat (3) @(posedge mclk_i);
			for (ch = 0; ch < 2; ch++)
				check("chan decode", {14'h0, fa[ch], fc[ch], mc[ch], sn[3*ch+:3],
					md[ch], vc[ch], ic[ch], wc[ch], we[ch], rg[5*ch+:5], hw[ch],
					lw[ch]}, {14'h0, exp_ch(ch ? c1 : c0, lp[ch], mp[ch],
					lvl[8*ch+:8] > 8'hA0, lvl[8*ch+:8] < 8'h60)});
		end
		apb(1'b0, PMD_OFS_CTRL1, 32'h0);
		check("ctrl1 readback", rd, {22'h0, c1});
		for (i = 0; i < 4; i++) begin
			apb(1'b1, PMD_OFS_SHARED, i);
			apb(1'b0, PMD_OFS_SHARED, 32'h0);
			check("shared switches", {30'h0, ess, efs}, i);
			check("shared readback", rd, i);
		end
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		// Interrupt: a falling force output on channel 0 sets its bit
		lp <= 2'b11;
		apb(1'b1, PMD_OFS_CTRL0, 32'h1);
		apb(1'b1, PMD_OFS_IRQ_EN, 32'h0);
		apb(1'b1, PMD_OFS_IRQ_CLR, 32'h3);
		apb(1'b0, PMD_OFS_IRQ_ST, 32'h0);
		check("irq status clear", rd, 32'h0);
		lp <= 2'b10;
		repeat (3) @(posedge mclk_i);
		apb(1'b0, PMD_OFS_IRQ_ST, 32'h0);
		check("irq status set", rd[0], 1'b1);
		// Channel 0 off by its pin: only the raw window bits may show
		apb(1'b0, PMD_OFS_STATUS, 32'h0);
		check("status ch0", rd[7:0],
			{lvl[7:0] < 8'h60, lvl[7:0] > 8'hA0, 6'h0});
		check("irq masked", irq_o, 1'b0);
		apb(1'b1, PMD_OFS_IRQ_EN, 32'h1);
		@(posedge mclk_i);
		check("irq raised", irq_o, 1'b1);
		apb(1'b1, PMD_OFS_IRQ_EN, 32'h0);
		@(posedge mclk_i);
		check("irq remasked", irq_o, 1'b0);
		apb(1'b1, PMD_OFS_IRQ_EN, 32'h1);
		apb(1'b1, PMD_OFS_IRQ_CLR, 32'h1);
		@(posedge mclk_i);
		check("irq cleared", irq_o, 1'b0);
		apb(1'b0, PMD_OFS_IRQ_ST, 32'h0);
		check("irq status after clear", rd, 32'h0);
		end_of_test();
	end
endmodule
